// ### rsf_map.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the receive status and front-end control block.
 * assumes a byte-wide register port with byte offsets as printed.
 */
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH

// register offsets
`define RSF_OFS_OPSTAT      8'h02
`define RSF_OFS_RXCTL1      8'h15
`define RSF_OFS_CFGAUX      8'h33
`define RSF_OFS_CFOPRE      8'h34
`define RSF_OFS_OFSMEAS     8'h35
`define RSF_OFS_TXACC       8'h3C
`define RSF_OFS_AMPCFG      8'h3D
`define RSF_OFS_LNACFG      8'h3E

// receive control one field positions
`define RSF_RX_EN_BIT       7
`define RSF_NO_PARSE_BIT    6
`define RSF_DECRYPT_BIT     5
`define RSF_APP_LQI_BIT     4
`define RSF_APP_RSSI_BIT    3
`define RSF_APP_CHANNEL_FORMAT_RATE_BIT    2
`define RSF_APP_CFO_BIT     1

// amplifier configuration field positions
`define RSF_POL_BIT         6
`define RSF_HEN_BIT         5

// auxiliary configuration: offset override bit
`define RSF_OVR_BIT         0

// reset values
`define RSF_RST_RXCTL1      8'h00
`define RSF_RST_TXACC       5'h00
`define RSF_RST_AMPCFG      8'h00
`define RSF_RST_LNACFG      8'h04

// radio operation codes
`define RSF_OP_TXPA         3'h7
`define RSF_OP_RXLNA        3'h6
`define RSF_OP_SYNTH        3'h5
`define RSF_OP_IDLE         3'h0

// one microsecond step at 100 MHz
`define RSF_STEP_NS         1000
`define RSF_CLK_NS          10
`define RSF_STEP_CYC        (`RSF_STEP_NS / `RSF_CLK_NS)

`endif

// ### rsf_pkg.sv
/*
 * types for the receive status and front-end control block.
 * assumes rsf_map.svh holds all numeric constants.
 */
package rsf_pkg;

   // front-end sequencer states
   typedef enum logic [2:0] {
      RSF_IDLE  = 3'b000,
      RSF_TXUP  = 3'b001,
      RSF_TXON  = 3'b010,
      RSF_RXUP  = 3'b011,
      RSF_RXON  = 3'b100
   } rsf_fe_state_t;

   // status vector append states
   typedef enum logic [2:0] {
      RSF_AP_IDLE = 3'b000,
      RSF_AP_LQI  = 3'b001,
      RSF_AP_RSSI = 3'b010,
      RSF_AP_CHANNEL_FORMAT_RATE = 3'b011,
      RSF_AP_CFO  = 3'b100
   } rsf_ap_state_t;

endpackage : rsf_pkg

// ### rsf_us_tick.sv
/*
 * microsecond enable divider.
 * assumes a 100 MHz clock; emits one-cycle pulses every step.
 */
`timescale 1ns/1ns
`include "rsf_map.svh"

module rsf_us_tick
   import rsf_pkg::*;
#(
   parameter int unsigned DIV = `RSF_STEP_CYC
)(
   input  wire logic clk,
   input  wire logic sys_rst,
   output logic      tick
);

   logic [7:0] cnt_q;

   // free running divider
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (cnt_q == 8'(DIV - 1)) begin
         cnt_q <= 8'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick  <= 1'b0;
      end
   end

endmodule : rsf_us_tick

// ### rsf_delay.sv
/*
 * microsecond delay counter: counts a programmed number of ticks.
 * assumes tick is a one-cycle enable from rsf_us_tick.
 */
`timescale 1ns/1ns
`include "rsf_map.svh"

module rsf_delay
   import rsf_pkg::*;
#(
   parameter int unsigned W = 5
)(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         start,
   input  wire logic         tick,
   input  wire logic [W-1:0] len,
   output logic              done
);

   logic [W-1:0] cnt_q;
   logic         run_q;

   // load on start, count down on ticks, done when zero reached
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (start) begin
         cnt_q <= len;
         run_q <= 1'b1;
      end else if (run_q && cnt_q == '0) begin
         run_q <= 1'b0;
      end else if (run_q && tick) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign done = run_q && (cnt_q == '0) && !start;

endmodule : rsf_delay

// ### rsf_ctrl.sv
/*
 * receive control/status, status vector appending, offset readout and
 * external amplifier sequencing.
 * assumes the radio core supplies packet, measurement and mode events
 * on the same clock, and the security engine reports completion.
 */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "rsf_map.svh"

module rsf_ctrl
   import rsf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // radio core events and measurements
   input  wire logic       mode_tx_stream,
   input  wire logic       mode_rx_stream,
   input  wire logic       rx_frame_start_flag,
   input  wire logic       pkt_active,
   input  wire logic       pkt_end,
   input  wire logic       frame_done,
   input  wire logic [7:0] cfo_est,
   input  wire logic [7:0] lqi_meas,
   input  wire logic [7:0] rssi_meas,
   input  wire logic [3:0] channel_code,
   input  wire logic       frame_format,
   input  wire logic [2:0] rate_code,
   input  wire logic       cca_req,
   input  wire logic       ack_wait,
   input  wire logic       tx_req,
   input  wire logic       synth_on,
   input  wire logic       sec_done,
   // outputs to the receive path
   output logic            pkt_discard,
   output logic            parse_en,
   output logic            cfo_est_en,
   output logic      [3:0] rx_precomp,
   output logic            sec_start,
   output logic            rx_on,
   output logic            rx_valid,
   // status vector write port into the packet buffer
   output logic            app_we,
   output logic      [7:0] app_data,
   // transmit path
   output logic            tx_on,
   output logic            tx_go,
   // external amplifier pins
   output logic            amp_pin,
   output logic            lna_pin
);

   ////////////////////////////////////////////////////////////////////
   // registers

   logic [7:0]    rxctl_q;
   logic [4:0]    txacc_q;
   logic [7:0]    ampcfg_q;
   logic [7:0]    lnacfg_q;
   logic [7:0]    cfopre_q;
   logic          ovr_q;
   logic [7:0]    ofs_q;
   logic [2:0]    radio_operation_state;
   rsf_fe_state_t fe_q;
   logic          rx_en;
   logic          tick;
   logic          tx_dly_done;
   logic          amp_dly_done;
   logic          lna_dly_done;
   logic          fe_start_tx;
   logic          fe_start_rx;
   logic          rx_need;

   assign rx_en = rxctl_q[`RSF_RX_EN_BIT];

   // write decode helper
   function automatic logic wr_hit(input logic [7:0] a);
      return reg_wr && (reg_addr == a);
   endfunction : wr_hit

   // receive control one: mode writes and self-clear beat host writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxctl_q <= `RSF_RST_RXCTL1;
      end else begin
         if (wr_hit(`RSF_OFS_RXCTL1)) begin
            rxctl_q <= {reg_wdata[7:1], 1'b0};
         end
         if (mode_tx_stream) begin
            rxctl_q[`RSF_RX_EN_BIT] <= 1'b0;
         end else if (mode_rx_stream) begin
            rxctl_q[`RSF_RX_EN_BIT] <= 1'b1;
         end
         if (sec_done) begin
            rxctl_q[`RSF_DECRYPT_BIT] <= 1'b0;
         end
      end
   end

   // front-end and precompensation configuration
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txacc_q  <= `RSF_RST_TXACC;
         ampcfg_q <= `RSF_RST_AMPCFG;
         lnacfg_q <= `RSF_RST_LNACFG;
         cfopre_q <= 8'h00;
         ovr_q    <= 1'b0;
      end else begin
         if (wr_hit(`RSF_OFS_TXACC))  txacc_q  <= reg_wdata[4:0];
         if (wr_hit(`RSF_OFS_AMPCFG)) ampcfg_q <= {1'b0, reg_wdata[6:0]};
         if (wr_hit(`RSF_OFS_LNACFG)) lnacfg_q <= {1'b0, reg_wdata[6:0]};
         if (wr_hit(`RSF_OFS_CFOPRE)) cfopre_q <= reg_wdata;
         if (wr_hit(`RSF_OFS_CFGAUX)) ovr_q    <= reg_wdata[`RSF_OVR_BIT];
      end
   end

   // offset measurement: loaded at frame start unless overridden, cleared at frame end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ofs_q <= 8'h00;
      end else if (rx_frame_start_flag && !ovr_q) begin
         ofs_q <= cfo_est;
      end else if (frame_done) begin
         ofs_q <= 8'h00;
      end
   end

   // override disables estimation and masks receive precompensation
   assign cfo_est_en = !ovr_q;
   assign rx_precomp = ovr_q ? 4'h0 : cfopre_q[3:0];

   // parsing and security processing controls
   assign parse_en  = !rxctl_q[`RSF_NO_PARSE_BIT];
   assign sec_start = rxctl_q[`RSF_DECRYPT_BIT];

   // read data one cycle after the strobe; reserved bits read zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RSF_OFS_OPSTAT:  reg_rdata <= {5'h00, radio_operation_state};
            `RSF_OFS_RXCTL1:  reg_rdata <= rxctl_q;
            `RSF_OFS_CFGAUX:  reg_rdata <= {7'h00, ovr_q};
            `RSF_OFS_CFOPRE:  reg_rdata <= cfopre_q;
            `RSF_OFS_OFSMEAS: reg_rdata <= ofs_q;
            `RSF_OFS_TXACC:   reg_rdata <= {3'h0, txacc_q};
            `RSF_OFS_AMPCFG:  reg_rdata <= ampcfg_q;
            `RSF_OFS_LNACFG:  reg_rdata <= lnacfg_q;
            default:          reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // packet abort

   logic rx_en_prev_q;

   // falling receive enable during a packet discards it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_en_prev_q <= 1'b0;
         pkt_discard  <= 1'b0;
      end else begin
         rx_en_prev_q <= rx_en;
         pkt_discard  <= rx_en_prev_q && !rx_en && pkt_active;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status vector appending, after the frame, length untouched

   rsf_ap_state_t ap_q;
   logic [3:0]    ap_en_q;
   logic [7:0]    cfo_frame_q;

   // next enabled field at or after a given slot
   function automatic rsf_ap_state_t ap_next(input logic [3:0] en,
                                             input int         from);
      rsf_ap_state_t r;
      r = RSF_AP_IDLE;
      // scan from the last slot so the earliest enabled slot wins
      for (int i = 0; i <= 3; i++) begin
         if (en[i] && (3 - i) >= from) r = rsf_ap_state_t'(4 - i);
      end
      return r;
   endfunction : ap_next

   // walk enabled fields in fixed order, one byte per cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ap_q        <= RSF_AP_IDLE;
         ap_en_q     <= 4'h0;
         cfo_frame_q <= 8'h00;
      end else begin
         if (rx_frame_start_flag) cfo_frame_q <= cfo_est;
         case (ap_q)
            RSF_AP_IDLE: begin
               if (pkt_end && !pkt_discard) begin
                  ap_en_q <= rxctl_q[4:1];
                  ap_q    <= ap_next(rxctl_q[4:1], 0);
               end
            end
            RSF_AP_LQI:  ap_q <= ap_next(ap_en_q, 1);
            RSF_AP_RSSI: ap_q <= ap_next(ap_en_q, 2);
            RSF_AP_CHANNEL_FORMAT_RATE: ap_q <= ap_next(ap_en_q, 3);
            RSF_AP_CFO:  ap_q <= RSF_AP_IDLE;
            default:     ap_q <= RSF_AP_IDLE;
         endcase
      end
   end

   // byte chosen by the current append slot; length field never written
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         app_we   <= 1'b0;
         app_data <= 8'h00;
      end else begin
         app_we <= (ap_q != RSF_AP_IDLE);
         case (ap_q)
            RSF_AP_LQI:  app_data <= lqi_meas;
            RSF_AP_RSSI: app_data <= rssi_meas;
            RSF_AP_CHANNEL_FORMAT_RATE: app_data <= {channel_code, frame_format,
                                      rate_code};
            RSF_AP_CFO:  app_data <= cfo_frame_q;
            default:     app_data <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // front-end sequencing

   rsf_us_tick u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   // amplifier wait: external amplifier delay when enabled, else tx delay
   logic [4:0] tx_len;
   assign tx_len = ampcfg_q[`RSF_HEN_BIT] ? ampcfg_q[4:0] : txacc_q;

   rsf_delay #(.W(5)) u_txdly (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (fe_start_tx),
      .tick    (tick),
      .len     (tx_len),
      .done    (tx_dly_done)
   );

   rsf_delay #(.W(5)) u_lownoise_delay (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (fe_start_rx),
      .tick    (tick),
      .len     (lnacfg_q[4:0]),
      .done    (lna_dly_done)
   );

   assign amp_dly_done = tx_dly_done;
   assign rx_need      = rx_en || cca_req || ack_wait;
   assign fe_start_tx  = (fe_q == RSF_IDLE) && tx_req;
   assign fe_start_rx  = (fe_q == RSF_IDLE) && !tx_req && rx_need;

   // transmit takes priority; receive entered on demand
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fe_q <= RSF_IDLE;
      end else begin
         case (fe_q)
            RSF_IDLE: begin
               if (fe_start_tx)      fe_q <= RSF_TXUP;
               else if (fe_start_rx) fe_q <= RSF_RXUP;
            end
            RSF_TXUP: begin
               if (!tx_req)           fe_q <= RSF_IDLE;
               else if (amp_dly_done) fe_q <= RSF_TXON;
            end
            RSF_TXON: if (!tx_req) fe_q <= RSF_IDLE;
            RSF_RXUP: begin
               if (!rx_need || tx_req) fe_q <= RSF_IDLE;
               else if (lna_dly_done)  fe_q <= RSF_RXON;
            end
            RSF_RXON: if (!rx_need || tx_req) fe_q <= RSF_IDLE;
            default:  fe_q <= RSF_IDLE;
         endcase
      end
   end

   logic amp_act;
   logic lna_act;
   assign amp_act = ampcfg_q[`RSF_HEN_BIT] &&
                    (fe_q == RSF_TXUP || fe_q == RSF_TXON);
   assign lna_act = lnacfg_q[`RSF_HEN_BIT] &&
                    (fe_q == RSF_RXUP || fe_q == RSF_RXON);

   // pins: active drives the polarity bit, inactive its inverse
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_pin <= 1'b1;
         lna_pin <= 1'b1;
      end else begin
         amp_pin <= amp_act ? ampcfg_q[`RSF_POL_BIT]
                            : !ampcfg_q[`RSF_POL_BIT];
         lna_pin <= lna_act ? lnacfg_q[`RSF_POL_BIT]
                            : !lnacfg_q[`RSF_POL_BIT];
      end
   end

   assign tx_on    = (fe_q == RSF_TXUP) || (fe_q == RSF_TXON);
   assign tx_go    = (fe_q == RSF_TXON);
   assign rx_on    = (fe_q == RSF_RXUP) || (fe_q == RSF_RXON);
   assign rx_valid = (fe_q == RSF_RXON);

   // radio operation status code
   always_comb begin
      if (amp_act)                       radio_operation_state = `RSF_OP_TXPA;
      else if (lna_act)                  radio_operation_state = `RSF_OP_RXLNA;
      else if (synth_on && (ampcfg_q[`RSF_HEN_BIT] ||
                            lnacfg_q[`RSF_HEN_BIT]))
                                         radio_operation_state = `RSF_OP_SYNTH;
      else                               radio_operation_state = `RSF_OP_IDLE;
   end

   ////////////////////////////////////////////////////////////////////
   // assertions

   AST_OFS_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
      rx_frame_start_flag && !ovr_q |=> ofs_q == $past(cfo_est))
      else $error("offset register not loaded at frame start");
   AST_OFS_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      ovr_q && !frame_done |=> $stable(ofs_q))
      else $error("offset register moved under override");
   AST_PRECOMP: assert property (@(posedge clk) disable iff (sys_rst)
      ovr_q |-> rx_precomp == 4'h0 && !cfo_est_en)
      else $error("precompensation not ignored under override");
   AST_STRM_TX: assert property (@(posedge clk) disable iff (sys_rst)
      mode_tx_stream |=> !rx_en)
      else $error("receive enable not cleared by tx streaming");
   AST_STRM_RX: assert property (@(posedge clk) disable iff (sys_rst)
      mode_rx_stream && !mode_tx_stream |=> rx_en)
      else $error("receive enable not set by rx streaming");
   AST_ABORT: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(rx_en) && pkt_active |=> pkt_discard)
      else $error("packet not discarded on receive disable");
   AST_FORCE_RX: assert property (@(posedge clk) disable iff (sys_rst)
      (cca_req || ack_wait) && !tx_req && fe_q == RSF_IDLE
      |=> fe_q == RSF_RXUP)
      else $error("radio not forced to receive");
   AST_DEC_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      sec_done |=> !rxctl_q[`RSF_DECRYPT_BIT])
      else $error("decrypt bit did not self-clear");
   AST_AMP_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      !ampcfg_q[`RSF_HEN_BIT] |=> amp_pin == !$past(ampcfg_q[6]))
      else $error("amplifier line active while disabled");
   // a zero delay legally reaches the on state in two cycles
   AST_TX_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
      fe_q == RSF_IDLE && tx_req && tx_len != 5'h00 ##1 tx_req[*2]
      |-> !tx_go)
      else $error("transmission began before access delay");
   AST_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
      ap_q == RSF_AP_LQI && ap_en_q[2] |=> ap_q == RSF_AP_RSSI)
      else $error("status vector fields out of order");
   AST_RADIO_OPERATION_STATE: assert property (@(posedge clk) disable iff (sys_rst)
      amp_act |-> radio_operation_state == 3'h7)
      else $error("operation status wrong during tx with amplifier");

   COV_TX: cover property (@(posedge clk) disable iff (sys_rst)
      fe_q == RSF_TXUP ##[1:1000] fe_q == RSF_TXON);
   COV_RX: cover property (@(posedge clk) disable iff (sys_rst)
      fe_q == RSF_RXUP ##[1:1000] fe_q == RSF_RXON);
   COV_APP: cover property (@(posedge clk) disable iff (sys_rst)
      ap_q == RSF_AP_LQI ##1 ap_q == RSF_AP_RSSI);
   COV_ABORT: cover property (@(posedge clk) disable iff (sys_rst)
      pkt_discard);

endmodule : rsf_ctrl

// ### rsf_amp_model.sv
/*
 * external amplifier pair: each one powers up while its control line
 * sits at the level given by its polarity bit.
 * assumes the bench mirrors the polarity bits that it writes.
 */
`timescale 1ns/1ns

module rsf_amp_model (
   input  wire logic amp_pin,
   input  wire logic lna_pin,
   input  wire logic amp_pol,
   input  wire logic lna_pol,
   output logic      amp_on,
   output logic      lna_on
);
   /////////////////////////////////////////////////////////////////////
   // powered only on an exact level match, so an unknown pin stays off
   assign amp_on = (amp_pin === amp_pol);
   assign lna_on = (lna_pin === lna_pol);
endmodule : rsf_amp_model

// ### rsf_ctrl_bench.sv
/*
 * self-checking bench for rsf_ctrl with the amplifier model.
 * assumes a 100 MHz clock and the design files compiled first.
 */
`timescale 1ns/1ns

module rsf_ctrl_bench
   import rsf_pkg::*;
;
   logic       clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, cfo_est = 0;
   logic [7:0] lqi_meas = 0, rssi_meas = 0, app_data;
   logic [3:0] channel_code = 0, rx_precomp;
   logic [2:0] rate_code = 0;
   logic       mode_tx_stream = 0, mode_rx_stream = 0, pkt_end = 0;
   logic       rx_frame_start_flag = 0, pkt_active = 0, frame_done = 0;
   logic       frame_format = 0, cca_req = 0, tx_req = 0, sec_done = 0;
   logic       pkt_discard, parse_en, cfo_est_en, sec_start, rx_on;
   logic       rx_valid, app_we, tx_on, tx_go, amp_pin, lna_pin;
   logic       amp_on, lna_on, amp_pol = 0, lna_pol = 0, rd_q = 0;
   logic       seen, ack_wait = 0, synth_on = 0;
   logic [7:0] exp_rd[$], exp_ap[$];
   logic [7:0] ra[5] = '{8'h15, 8'h3C, 8'h3D, 8'h3E, 8'h50};
   logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
   int         n_errors = 0, n_compared = 0, cyc = 0, t;

   rsf_ctrl dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .mode_tx_stream, .mode_rx_stream,
      .rx_frame_start_flag, .pkt_active, .pkt_end, .frame_done, .cfo_est,
      .lqi_meas, .rssi_meas, .channel_code, .frame_format, .rate_code,
      .cca_req, .ack_wait, .tx_req, .synth_on, .sec_done,
      .pkt_discard, .parse_en, .cfo_est_en, .rx_precomp, .sec_start,
      .rx_on, .rx_valid, .app_we, .app_data, .tx_on, .tx_go, .amp_pin,
      .lna_pin);
   rsf_amp_model amp_u (.amp_pin, .lna_pin, .amp_pol, .lna_pol, .amp_on,
      .lna_on);

   /////////////////////////////////////////////////////////////////////
   // clock
   always #5 clk = ~clk;

   /////////////////////////////////////////////////////////////////////
   // compare, verdict and bus tasks
   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] e);
      exp_rd.push_back(e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   /////////////////////////////////////////////////////////////////////
   // monitor: oldest note against each read answer or appended byte
   always @(posedge clk) begin
      rd_q <= reg_rd;
      cyc <= cyc + 1;
      if (rd_q)
         chk("rdata", reg_rdata, exp_rd.pop_front());
      if (app_we)
         chk("append", app_data, exp_ap.pop_front());
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end

   /////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(5397));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (ra[i])
         rd(ra[i], rv[i]);
      wr(8'h15, 8'h1F);
      rd(8'h15, 8'h1E);
      wr(8'h3C, 8'h1F);
      rd(8'h3C, 8'h1F);
      wr(8'h3C, 8'h01);
      // offset capture, then status vector append
      @(posedge clk);
      cfo_est <= 8'($urandom);
      lqi_meas <= 8'($urandom);
      rssi_meas <= 8'($urandom);
      channel_code <= 4'($urandom);
      frame_format <= 1'($urandom);
      rate_code <= 3'($urandom);
      rx_frame_start_flag <= 1'b1;
      @(posedge clk);
      rx_frame_start_flag <= 1'b0;
      rd(8'h35, cfo_est);
      exp_ap = '{lqi_meas, rssi_meas, {channel_code, frame_format,
         rate_code}, cfo_est};
      pkt_end <= 1'b1;
      @(posedge clk);
      pkt_end <= 1'b0;
      repeat (8) @(posedge clk);
      chk("app_left", 8'(exp_ap.size()), 8'h00);
      frame_done <= 1'b1;
      @(posedge clk);
      frame_done <= 1'b0;
      rd(8'h35, 8'h00);
      // offset override
      wr(8'h34, 8'h05);
      @(negedge clk);
      chk("precomp", 8'(rx_precomp), 8'h05);
      wr(8'h33, 8'h01);
      @(negedge clk);
      chk("est_en", 8'(cfo_est_en), 8'h00);
      chk("precomp", 8'(rx_precomp), 8'h00);
      @(posedge clk);
      rx_frame_start_flag <= 1'b1;
      @(posedge clk);
      rx_frame_start_flag <= 1'b0;
      rd(8'h35, 8'h00);
      wr(8'h33, 8'h00);
      // no parse and decryption
      wr(8'h15, 8'h60);
      @(negedge clk);
      chk("parse_en", 8'(parse_en), 8'h00);
      chk("sec_start", 8'(sec_start), 8'h01);
      @(posedge clk);
      sec_done <= 1'b1;
      @(posedge clk);
      sec_done <= 1'b0;
      rd(8'h15, 8'h40);
      // streaming modes, then abort of a packet in progress
      mode_rx_stream <= 1'b1;
      @(posedge clk);
      mode_rx_stream <= 1'b0;
      rd(8'h15, 8'hC0);
      mode_tx_stream <= 1'b1;
      @(posedge clk);
      mode_tx_stream <= 1'b0;
      rd(8'h15, 8'h40);
      wr(8'h15, 8'hC0);
      pkt_active <= 1'b1;
      wr(8'h15, 8'h40);
      seen = 1'b0;
      repeat (5) @(posedge clk) seen |= pkt_discard;
      chk("discard", 8'(seen), 8'h01);
      pkt_active <= 1'b0;
      // amplifier handling with a two step access delay
      amp_pol <= 1'b1;
      wr(8'h3D, 8'h62);
      tx_req <= 1'b1;
      for (t = 0; t < 1000 && tx_go !== 1'b1; t++) @(posedge clk);
      chk("amp_wait", 8'(t >= 100 && t <= 310), 8'h01);
      chk("amp_on", 8'(amp_on), 8'h01);
      chk("tx_on", 8'(tx_on), 8'h01);
      rd(8'h02, 8'h07);
      tx_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk("amp_off", 8'(amp_on), 8'h00);
      // handling off: line inactive, transmitter delay used
      amp_pol <= 1'b0;
      wr(8'h3D, 8'h00);
      tx_req <= 1'b1;
      for (t = 0; t < 1000 && tx_go !== 1'b1; t++) @(posedge clk);
      chk("tx_wait", 8'(t <= 210), 8'h01);
      chk("amp_idle", 8'(amp_pin), 8'h01);
      tx_req <= 1'b0;
      // forced receive with low noise amplifier, active low
      wr(8'h3E, 8'h23);
      cca_req <= 1'b1;
      for (t = 0; t < 1000 && rx_valid !== 1'b1; t++) @(posedge clk);
      chk("lna_wait", 8'(t >= 200 && t <= 410), 8'h01);
      chk("lna_on", 8'(lna_on), 8'h01);
      chk("rx_on", 8'(rx_on), 8'h01);
      rd(8'h02, 8'h06);
      cca_req <= 1'b0;
      repeat (4) @(posedge clk);
      // synthesizer status, then forced receive for an awaited ack
      synth_on <= 1'b1;
      rd(8'h02, 8'h05);
      synth_on <= 1'b0;
      ack_wait <= 1'b1;
      repeat (2) @(posedge clk);
      chk("ack_rx", 8'(rx_on), 8'h01);
      ack_wait <= 1'b0;
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule : rsf_ctrl_bench
